// File: hw/wut_pkg.sv
// Package: register map, field layout and shared types of the wake-up timer
package wut_pkg;

    // ==========================================================
    // Register indexes (byte address is four times the index)
    localparam logic [7:0] IDX_CONTROL = 8'h23;
    localparam logic [7:0] IDX_RELOAD_HIGH = 8'h24;
    localparam logic [7:0] IDX_RELOAD_LOW = 8'h25;
    localparam logic [7:0] IDX_COUNT_HIGH = 8'h26;
    localparam logic [7:0] IDX_COUNT_LOW = 8'h27;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'h30;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h31;

    // ==========================================================
    // Control register field positions
    localparam int BIT_RUNNING = 7;
    localparam int BIT_RUN_CHANGE_ENABLE = 6;
    localparam int BIT_AUTO_TRIM = 5;
    localparam int BIT_AUTO_CARD_DETECT = 4;
    localparam int BIT_AUTO_RELOAD = 3;
    localparam int BIT_AUTO_EXIT_SLEEP = 2;
    localparam int BIT_CLOCK_SELECT_LSB = 0;

    // Interrupt status / mask bit positions
    localparam int IRQ_BIT_UNDERFLOW = 0;
    localparam int IRQ_BIT_CARD_FOUND = 1;
    localparam int IRQ_BITS = 2;

    // ==========================================================
    // Reset values
    localparam logic [7:0] RST_CONTROL = 8'h00;
    localparam logic [7:0] RST_RELOAD_BYTE = 8'h00;
    localparam logic [1:0] RST_IRQ = 2'h0;

    // ==========================================================
    // Prescale divide ratios for clock select codes 0..3
    localparam logic [5:0] DIV_SEL0 = 6'h01;
    localparam logic [5:0] DIV_SEL1 = 6'h08;
    localparam logic [5:0] DIV_SEL2 = 6'h10;
    localparam logic [5:0] DIV_SEL3 = 6'h20;

    // Persistent control settings
    typedef struct packed {
        logic auto_trim;
        logic auto_card_detect;
        logic auto_reload;
        logic auto_exit_sleep;
        logic [1:0] clock_select;
    } wut_ctrl_s;

    localparam wut_ctrl_s RST_CTRL_FIELDS = '0;

    // Card detection sequence
    typedef enum logic [1:0] {
        CD_IDLE,
        CD_FIELD,
        CD_RESULT
    } wut_cd_e;

    function automatic logic [5:0] wut_div_len(input logic [1:0] sel);
        case (sel)
            2'h0: wut_div_len = DIV_SEL0;
            2'h1: wut_div_len = DIV_SEL1;
            2'h2: wut_div_len = DIV_SEL2;
            default: wut_div_len = DIV_SEL3;
        endcase
    endfunction

endpackage

// File: hw/wut_prescale.sv
// Prescaler turning oscillator ticks into wake-up timer count ticks
`timescale 1ns/1ps
`default_nettype none
module wut_prescale (
    // Clock and control
    input wire logic mclk,
    input wire logic srst,
    input wire logic ce,
    // Oscillator tick and setup
    input wire logic lfo_tick,
    input wire logic [1:0] clock_select,
    input wire logic running,
    // Count tick
    output logic tick
);

    // ==========================================================
    // Divider
    logic [5:0] div_cnt;
    wire logic [5:0] div_len = wut_pkg::wut_div_len(clock_select);
    wire logic div_last = (div_cnt >= div_len - 6'h01);

    // Restart the divider while idle so each period begins whole
    always_ff @(posedge mclk) begin
        if (srst) begin
            div_cnt <= 6'h00;
            tick <= 1'b0;
        end else if (ce) begin
            tick <= 1'b0;
            if (!running) begin
                div_cnt <= 6'h00;
            end else if (lfo_tick) begin
                if (div_last) begin
                    div_cnt <= 6'h00;
                    tick <= 1'b1;
                end else begin
                    div_cnt <= div_cnt + 6'h01;
                end
            end
        end
    end

endmodule
`default_nettype wire

// File: hw/wut_top.sv
// Wake-up timer with Avalon-MM registers, card detect and interrupt
//
// Overview of operation
// - Control bit 7 reads whether timer runs
// - Run bit writes take effect only with bit 6 set
// - Auto-trim starts oscillator trimming at underflow
// - Auto card-detect starts detection at underflow when none is in progress
// - Card found raises interrupt; none found sleeps when auto-exit-sleep is set
// - Card-detect mode reloads at underflow, no gap
// - RF field on while third timer counts
// - Auto-reload reloads value and keeps counting
// - Without auto-reload or auto card-detect, halt at zero, clear running
// - Every underflow sets the underflow interrupt flag
// - Auto-exit-sleep wakes chip at every underflow
// - Clock select divides oscillator by 1/8/16/32
// - Start loads counter from 16-bit reload word
// - Reload writes affect only the next start or underflow reload
// - Live count readable as high, low bytes
//
// The Avalon-MM slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module wut_top #(
    parameter int COUNT_WIDTH = 16
) (
    // Clock, reset, enable
    input wire logic mclk,
    input wire logic srst,
    input wire logic ce,
    // Avalon-MM slave
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    // Oscillator and neighbouring blocks
    input wire logic lfo_tick,
    input wire logic field_timer_done,
    input wire logic card_result_valid,
    input wire logic card_found,
    input wire logic trim_done,
    // Events and controls towards neighbours
    output logic underflow_pulse,
    output logic trim_start,
    output logic card_detect_start,
    output logic rf_field_on,
    output logic wake_req,
    output logic sleep_req,
    output logic irq
);

    // ==========================================================
    // Register state
    wut_pkg::wut_ctrl_s ctrl;
    logic running;
    logic [7:0] reload_high;
    logic [7:0] reload_low;
    logic [COUNT_WIDTH-1:0] count;
    logic [wut_pkg::IRQ_BITS-1:0] irq_status;
    logic [wut_pkg::IRQ_BITS-1:0] irq_mask;
    wut_pkg::wut_cd_e cd_state;
    logic tick;

    // ==========================================================
    // Bus decode
    wire logic req = read | write;
    wire logic acc = req & ~waitrequest & ce;
    wire logic wr_acc = acc & write & byteenable[0];
    wire logic [7:0] word_idx = {2'b00, address[7:2]};
    wire logic sel_ctrl = (word_idx == wut_pkg::IDX_CONTROL);
    wire logic sel_rhi = (word_idx == wut_pkg::IDX_RELOAD_HIGH);
    wire logic sel_rlo = (word_idx == wut_pkg::IDX_RELOAD_LOW);
    wire logic sel_chi = (word_idx == wut_pkg::IDX_COUNT_HIGH);
    wire logic sel_clo = (word_idx == wut_pkg::IDX_COUNT_LOW);
    wire logic sel_ist = (word_idx == wut_pkg::IDX_IRQ_STATUS);
    wire logic sel_imk = (word_idx == wut_pkg::IDX_IRQ_MASK);
    wire logic ctrl_wr = wr_acc & sel_ctrl;
    wire logic [7:0] wbyte = writedata[7:0];
    wire logic run_change = ctrl_wr & wbyte[wut_pkg::BIT_RUN_CHANGE_ENABLE];
    wire logic start_now = run_change & wbyte[wut_pkg::BIT_RUNNING];

    wire logic [COUNT_WIDTH-1:0] reload_word =
        COUNT_WIDTH'({reload_high, reload_low});
    wire logic [15:0] count16 = 16'(count);

    // Change-enable reads back zero: it is write-only
    wire logic [7:0] ctrl_rd = {running, 1'b0, ctrl.auto_trim,
        ctrl.auto_card_detect, ctrl.auto_reload,
        ctrl.auto_exit_sleep, ctrl.clock_select};

    wire logic [7:0] rd_mux =
        sel_ctrl ? ctrl_rd :
        sel_rhi ? reload_high :
        sel_rlo ? reload_low :
        sel_chi ? count16[15:8] :
        sel_clo ? count16[7:0] :
        sel_ist ? {6'h00, irq_status} :
        sel_imk ? {6'h00, irq_mask} : 8'h00;

    // ==========================================================
    // Avalon handshake: one wait cycle, data sampled into a flop
    always_ff @(posedge mclk) begin
        if (srst) begin
            waitrequest <= 1'b1;
            readdata <= 32'h0000_0000;
        end else if (ce) begin
            if (req && waitrequest) begin
                waitrequest <= 1'b0;
                readdata <= read ? {24'h00_0000, rd_mux} : 32'h0000_0000;
            end else begin
                waitrequest <= 1'b1;
            end
        end
    end

    // ==========================================================
    // Settings and reload bytes
    always_ff @(posedge mclk) begin
        if (srst) begin
            ctrl <= wut_pkg::RST_CTRL_FIELDS;
            reload_high <= wut_pkg::RST_RELOAD_BYTE;
            reload_low <= wut_pkg::RST_RELOAD_BYTE;
            irq_mask <= wut_pkg::RST_IRQ;
        end else if (ce) begin
            if (ctrl_wr) begin
                ctrl <= wut_pkg::wut_ctrl_s'(wbyte[5:0]);
            end
            // Only the holding bytes change here, not the count
            if (wr_acc && sel_rhi) begin
                reload_high <= wbyte;
            end
            if (wr_acc && sel_rlo) begin
                reload_low <= wbyte;
            end
            if (wr_acc && sel_imk) begin
                irq_mask <= wbyte[wut_pkg::IRQ_BITS-1:0];
            end
        end
    end

    // ==========================================================
    // Prescaler
    wut_prescale u_prescale (
        .mclk(mclk),
        .srst(srst),
        .ce(ce),
        .lfo_tick(lfo_tick),
        .clock_select(ctrl.clock_select),
        .running(running),
        .tick(tick)
    );

    // ==========================================================
    // Countdown
    wire logic at_last = (count <= COUNT_WIDTH'(1));
    wire logic uf = ce & running & tick & at_last & ~run_change;
    wire logic keep_going = ctrl.auto_reload | ctrl.auto_card_detect;

    always_ff @(posedge mclk) begin
        if (srst) begin
            running <= 1'b0;
            count <= '0;
        end else if (ce) begin
            if (run_change) begin
                running <= wbyte[wut_pkg::BIT_RUNNING];
                if (start_now) begin
                    count <= reload_word;
                end
            end else if (uf) begin
                if (keep_going) begin
                    count <= reload_word;
                end else begin
                    count <= '0;
                    running <= 1'b0;
                end
            end else if (running && tick) begin
                count <= count - COUNT_WIDTH'(1);
            end
        end
    end

    // ==========================================================
    // Card detection sequence
    wire logic cd_launch = uf & ctrl.auto_card_detect &
        (cd_state == wut_pkg::CD_IDLE);
    wire logic cd_done = (cd_state == wut_pkg::CD_RESULT) & card_result_valid;
    wire logic card_ev = cd_done & card_found;
    // Sleep only when asked; otherwise chip stays active
    wire logic go_sleep = ctrl.auto_exit_sleep &
        ((cd_done & ~card_found) | trim_done);

    always_ff @(posedge mclk) begin
        if (srst) begin
            cd_state <= wut_pkg::CD_IDLE;
            rf_field_on <= 1'b0;
        end else if (ce) begin
            case (cd_state)
                wut_pkg::CD_IDLE: begin
                    if (cd_launch) begin
                        cd_state <= wut_pkg::CD_FIELD;
                        rf_field_on <= 1'b1;
                    end
                end
                wut_pkg::CD_FIELD: begin
                    if (field_timer_done) begin
                        cd_state <= wut_pkg::CD_RESULT;
                        rf_field_on <= 1'b0;
                    end
                end
                wut_pkg::CD_RESULT: begin
                    if (card_result_valid) begin
                        cd_state <= wut_pkg::CD_IDLE;
                    end
                end
                default: begin
                    cd_state <= wut_pkg::CD_IDLE;
                    rf_field_on <= 1'b0;
                end
            endcase
        end
    end

    // ==========================================================
    // Event pulses
    always_ff @(posedge mclk) begin
        if (srst) begin
            underflow_pulse <= 1'b0;
            trim_start <= 1'b0;
            card_detect_start <= 1'b0;
            wake_req <= 1'b0;
            sleep_req <= 1'b0;
        end else if (ce) begin
            underflow_pulse <= uf;
            trim_start <= uf & ctrl.auto_trim;
            card_detect_start <= cd_launch;
            wake_req <= uf & ctrl.auto_exit_sleep;
            sleep_req <= go_sleep;
        end
    end

    // ==========================================================
    // Interrupts: a new event wins over a same-cycle clear
    wire logic [wut_pkg::IRQ_BITS-1:0] irq_set = {card_ev, uf};
    wire logic [wut_pkg::IRQ_BITS-1:0] irq_clr =
        (wr_acc & sel_ist) ? wbyte[wut_pkg::IRQ_BITS-1:0] : '0;

    always_ff @(posedge mclk) begin
        if (srst) begin
            irq_status <= wut_pkg::RST_IRQ;
            irq <= 1'b0;
        end else if (ce) begin
            irq_status <= (irq_status & ~irq_clr) | irq_set;
            irq <= |(irq_status & irq_mask);
        end
    end

    // ==========================================================
    // Assertions
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (srst);

    sequence s_bus_read_ctrl;
        req && waitrequest && ce && read && sel_ctrl;
    endsequence

    sequence s_settled_start;
        ##1 running && count == $past(reload_word);
    endsequence

    running_readback_a: assert property (
        s_bus_read_ctrl |=> readdata[7] == $past(running))
        else $error("running bit readback wrong");

    run_guard_a: assert property (
        ctrl_wr && !wbyte[6] && !uf |=> running == $past(running))
        else $error("running changed without change enable");

    start_load_a: assert property (
        start_now |-> s_settled_start)
        else $error("start did not load reload word");

    trim_launch_a: assert property (
        uf && ctrl.auto_trim |=> trim_start)
        else $error("trim not launched at underflow");

    detect_launch_a: assert property (
        cd_launch |=> card_detect_start && rf_field_on)
        else $error("card detection not started");

    field_hold_a: assert property (
        rf_field_on && !field_timer_done |=> rf_field_on)
        else $error("rf field dropped before interval end");

    no_gap_a: assert property (
        uf && ctrl.auto_card_detect |-> s_settled_start)
        else $error("card detect mode left a gap");

    halt_zero_a: assert property (
        uf && !keep_going |=> !running && count == '0)
        else $error("timer did not halt at zero");

    underflow_flag_a: assert property (
        uf |=> irq_status[0] ##1 (irq || !$past(irq_mask[0]) || !$past(ce)))
        else $error("underflow flag not set");

    auto_wake_a: assert property (
        uf && ctrl.auto_exit_sleep |=> wake_req && underflow_pulse)
        else $error("wake request missing");

    reload_quiet_a: assert property (
        wr_acc && (sel_rhi || sel_rlo) && !tick |=> count == $past(count))
        else $error("reload write disturbed countdown");

    decrement_a: assert property (
        ce && running && tick && !at_last && !run_change
        |=> count == $past(count) - COUNT_WIDTH'(1))
        else $error("count did not step down by one");

    run_follow_a: assert property (
        run_change |=> running == $past(wbyte[wut_pkg::BIT_RUNNING]))
        else $error("running did not follow written bit");

    card_flag_a: assert property (
        ce && card_ev |=> irq_status[wut_pkg::IRQ_BIT_CARD_FOUND])
        else $error("card found flag not set");

    no_card_sleep_a: assert property (
        ce && cd_done && !card_found && ctrl.auto_exit_sleep |=> sleep_req)
        else $error("sleep request missing after empty detection");

    field_off_a: assert property (
        ce && cd_state == wut_pkg::CD_FIELD && field_timer_done
        |=> !rf_field_on)
        else $error("rf field not dropped at interval end");

    // Held tick while frozen is legal, so only fresh ticks are traced
    tick_source_a: assert property (
        tick && $past(ce) |-> $past(lfo_tick))
        else $error("count tick without oscillator tick");

endmodule
`default_nettype wire

// File: verif/tb.sv
// Self-checking bench for the wake-up timer block
`timescale 1ns/1ps
`default_nettype none
module tb;
    // ==========================================================
    // Signals
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic ce = 1'b1;
    logic [7:0] address = 8'h00;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [3:0] byteenable = 4'hF;
    logic [31:0] writedata = 32'h0;
    logic [31:0] readdata;
    logic waitrequest;
    logic lfo_tick = 1'b0;
    logic field_timer_done = 1'b0;
    logic card_result_valid = 1'b0;
    logic card_found = 1'b0;
    logic trim_done = 1'b0;
    logic underflow_pulse, trim_start, card_detect_start;
    logic rf_field_on, wake_req, sleep_req, irq;
    int failures = 0;
    int checked = 0;
    int n_uf = 0, n_trim = 0, n_cd = 0, n_wake = 0, n_sleep = 0;
    logic [7:0] exp_q[$];
    logic [7:0] rh, rl;
    logic [15:0] rv;
    int dv[4] = '{1, 8, 16, 32};

    always #2 mclk = ~mclk;

    wut_top wut_top_i (
        .mclk(mclk), .srst(srst), .ce(ce),
        .address(address), .read(read), .write(write),
        .byteenable(byteenable), .writedata(writedata),
        .readdata(readdata), .waitrequest(waitrequest),
        .lfo_tick(lfo_tick), .field_timer_done(field_timer_done),
        .card_result_valid(card_result_valid), .card_found(card_found),
        .trim_done(trim_done), .underflow_pulse(underflow_pulse),
        .trim_start(trim_start), .card_detect_start(card_detect_start),
        .rf_field_on(rf_field_on), .wake_req(wake_req),
        .sleep_req(sleep_req), .irq(irq)
    );

    // ==========================================================
    // Compare tasks and closing
    task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic check_bit(input logic got, input logic exp);
        check_val({31'h0, got}, {31'h0, exp});
    endtask

    task automatic summarize;
        $display("checked=%0d failures=%0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // ==========================================================
    // Bus master: hold request until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [7:0] idx,
                       input logic [7:0] d, input logic be);
        int n;
        @(posedge mclk);
        read <= ~wr;
        write <= wr;
        address <= {idx[5:0], 2'b00};
        writedata <= {24'h0, d};
        byteenable <= {3'h7, be};
        n = 0;
        @(posedge mclk);
        while (waitrequest !== 1'b0 && n < 50) begin
            n++;
            @(posedge mclk);
        end
        if (n >= 50) failures++;
        read <= 1'b0;
        write <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        bus(1'b1, idx, d, 1'b1);
    endtask

    // Expected value is noted first, monitor compares at completion
    task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
        exp_q.push_back(exp);
        bus(1'b0, idx, 8'h00, 1'b1);
    endtask

    always @(posedge mclk) begin
        if (read === 1'b1 && waitrequest === 1'b0) begin
            if (exp_q.size() == 0) failures++;
            else check_val(readdata, {24'h0, exp_q.pop_front()});
        end
    end

    // Event outputs are single-cycle pulses, counted every edge
    always @(posedge mclk) begin
        if (!srst) begin
            n_uf += int'(underflow_pulse === 1'b1);
            n_trim += int'(trim_start === 1'b1);
            n_cd += int'(card_detect_start === 1'b1);
            n_wake += int'(wake_req === 1'b1);
            n_sleep += int'(sleep_req === 1'b1);
        end
    end

    // Oscillator ticks spaced apart so the prescaler sees each one
    task automatic low_freq_oscillator(input int n);
        repeat (n) begin
            @(posedge mclk);
            lfo_tick <= 1'b1;
            @(posedge mclk);
            lfo_tick <= 1'b0;
            repeat (2) @(posedge mclk);
        end
        repeat (4) @(posedge mclk);
    endtask

    task automatic ev(input int which, input logic f);
        @(posedge mclk);
        case (which)
            0: field_timer_done <= 1'b1;
            1: trim_done <= 1'b1;
            default: begin
                card_result_valid <= 1'b1;
                card_found <= f;
            end
        endcase
        @(posedge mclk);
        field_timer_done <= 1'b0;
        trim_done <= 1'b0;
        card_result_valid <= 1'b0;
        card_found <= 1'b0;
        repeat (4) @(posedge mclk);
    endtask

    initial begin
        #100000;
        failures++;
        summarize();
    end

    // ==========================================================
    // Main sequence
    initial begin
        void'($urandom(32'hC49B));
        repeat (5) @(posedge mclk);
        srst <= 1'b0;
        // Reset contents, unmapped place, masked-off byte lane
        rd(wut_pkg::IDX_CONTROL, 8'h00);
        rd(wut_pkg::IDX_COUNT_HIGH, 8'h00);
        rd(wut_pkg::IDX_IRQ_STATUS, 8'h00);
        wr(8'h10, 8'hFF);
        rd(8'h10, 8'h00);
        rh = 8'($urandom_range(255, 1));
        rl = 8'($urandom());
        rv = {rh, rl};
        wr(wut_pkg::IDX_RELOAD_HIGH, rh);
        wr(wut_pkg::IDX_RELOAD_LOW, rl);
        bus(1'b1, wut_pkg::IDX_RELOAD_LOW, ~rl, 1'b0);
        rd(wut_pkg::IDX_RELOAD_HIGH, rh);
        rd(wut_pkg::IDX_RELOAD_LOW, rl);
        // Every clock select: one count step per divided tick
        for (int s = 0; s < 4; s++) begin
            wr(wut_pkg::IDX_CONTROL, 8'h40);
            rd(wut_pkg::IDX_CONTROL, 8'h00);
            wr(wut_pkg::IDX_CONTROL, 8'hC0 | 8'(s));
            wr(wut_pkg::IDX_CONTROL, 8'(s));
            rd(wut_pkg::IDX_CONTROL, 8'h80 | 8'(s));
            rd(wut_pkg::IDX_COUNT_LOW, rv[7:0]);
            low_freq_oscillator(dv[s] - 1);
            rd(wut_pkg::IDX_COUNT_LOW, rv[7:0]);
            low_freq_oscillator(1);
            rd(wut_pkg::IDX_COUNT_LOW, 8'(rv - 16'h1));
            rd(wut_pkg::IDX_COUNT_HIGH, 8'((rv - 16'h1) >> 8));
        end
        // Reload writes leave the running countdown alone
        wr(wut_pkg::IDX_RELOAD_HIGH, 8'h00);
        wr(wut_pkg::IDX_RELOAD_LOW, 8'h02);
        rd(wut_pkg::IDX_COUNT_LOW, 8'(rv - 16'h1));
        rd(wut_pkg::IDX_COUNT_HIGH, 8'((rv - 16'h1) >> 8));
        // Auto-reload with trim and wake, interrupt masked in
        wr(wut_pkg::IDX_IRQ_MASK, 8'h01);
        wr(wut_pkg::IDX_CONTROL, 8'hEC);
        rd(wut_pkg::IDX_CONTROL, 8'hAC);
        // Clock enable low freezes the countdown
        ce <= 1'b0;
        low_freq_oscillator(2);
        ce <= 1'b1;
        rd(wut_pkg::IDX_COUNT_LOW, 8'h02);
        low_freq_oscillator(1);
        check_val(32'(n_uf), 32'h0);
        low_freq_oscillator(1);
        check_val(32'(n_uf), 32'h1);
        check_val(32'(n_trim), 32'h1);
        check_val(32'(n_wake), 32'h1);
        check_bit(irq, 1'b1);
        rd(wut_pkg::IDX_COUNT_LOW, 8'h02);
        rd(wut_pkg::IDX_CONTROL, 8'hAC);
        rd(wut_pkg::IDX_IRQ_STATUS, 8'h01);
        wr(wut_pkg::IDX_IRQ_STATUS, 8'h01);
        repeat (2) @(posedge mclk);
        check_bit(irq, 1'b0);
        wr(wut_pkg::IDX_IRQ_MASK, 8'h00);
        low_freq_oscillator(2);
        rd(wut_pkg::IDX_IRQ_STATUS, 8'h01);
        check_bit(irq, 1'b0);
        check_val(32'(n_trim), 32'h2);
        wr(wut_pkg::IDX_IRQ_STATUS, 8'h01);
        ev(1, 1'b0);
        check_val(32'(n_sleep), 32'h1);
        // Single shot: halt at zero and clear running
        wr(wut_pkg::IDX_CONTROL, 8'h40);
        wr(wut_pkg::IDX_RELOAD_LOW, 8'h01);
        wr(wut_pkg::IDX_CONTROL, 8'hC0);
        low_freq_oscillator(1);
        rd(wut_pkg::IDX_CONTROL, 8'h00);
        rd(wut_pkg::IDX_COUNT_LOW, 8'h00);
        low_freq_oscillator(3);
        check_val(32'(n_uf), 32'h3);
        check_val(32'(n_wake), 32'h2);
        // Card detection: found, then not found
        wr(wut_pkg::IDX_RELOAD_LOW, 8'h02);
        wr(wut_pkg::IDX_IRQ_MASK, 8'h02);
        wr(wut_pkg::IDX_IRQ_STATUS, 8'h03);
        wr(wut_pkg::IDX_CONTROL, 8'hD4);
        for (int k = 0; k < 2; k++) begin
            low_freq_oscillator(2);
            check_val(32'(n_cd), 32'(k + 1));
            check_bit(rf_field_on, 1'b1);
            rd(wut_pkg::IDX_COUNT_LOW, 8'h02);
            rd(wut_pkg::IDX_CONTROL, 8'h94);
            ev(0, 1'b0);
            check_bit(rf_field_on, 1'b0);
            ev(2, k == 0);
            check_bit(irq, k == 0);
            rd(wut_pkg::IDX_IRQ_STATUS, k == 0 ? 8'h03 : 8'h01);
            check_val(32'(n_sleep), 32'(k + 1));
            wr(wut_pkg::IDX_IRQ_STATUS, 8'h03);
        end
        check_val(32'(n_wake), 32'h4);
        repeat (4) @(posedge mclk);
        check_val(32'(exp_q.size()), 32'h0);
        summarize();
    end
endmodule
`default_nettype wire
